// ===== rtl/host_port_consts.vh
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define OFS_HARDWARE_MODE_CONTROL 16'h0300
`define OFS_INTERRUPT_STATUS 16'h0310
`define OFS_INTERRUPT_ENABLE 16'h0314
`define OFS_EDGE_IRQ_TIMING 16'h0318
`define OFS_DMA_CONFIGURATION 16'h0330
`define OFS_DMA_TRANSFER_COUNT 16'h0334
`define OFS_DMA_START_ADDRESS 16'h0338
`define OFS_READ_PREFETCH_ADDRESS 16'h033C
`define MEM_SPACE_LOW 16'h0400
// ****************************************
// field positions
// ****************************************
`define HW_GLOBAL_EN_BIT 0
`define HW_TRIGGER_BIT 1
`define HW_POLARITY_BIT 2
`define HW_ACK_HIGH_BIT 5
`define HW_REQ_HIGH_BIT 6
`define HW_BUS32_BIT 8
`define DCFG_DIR_BIT 0
`define DCFG_ENABLE_BIT 1
`define DCFG_BURST_LSB 2
`define IRQ_DMA_DONE_BIT 3
// ****************************************
// reset values and timing
// ****************************************
`define HW_MODE_RESET 32'h00000000
`define CLK_PERIOD_NS 10
`define IRQ_PULSE_DEFAULT_NS 500
`define IRQ_PULSE_DEFAULT_CNT (`IRQ_PULSE_DEFAULT_NS / `CLK_PERIOD_NS)
`define EDGE_TIMING_RESET {16'h0000, 16'h0032}
`define IRQ_SPACE_TICK_NS 2560
`define IRQ_SPACE_TICK_CYC (`IRQ_SPACE_TICK_NS / `CLK_PERIOD_NS)
`endif

// ===== rtl/prefetch_bank_store.v
`timescale 1ns/100ps
// ****************************************
// per-bank read pointer and pre-fetched word store
// ****************************************
module prefetch_bank_store (
    input wire clk,
    input wire rst_n,
    input wire load_en,
    input wire [1:0] load_bank,
    input wire [15:0] load_addr,
    input wire fill_en,
    input wire [1:0] fill_bank,
    input wire [31:0] fill_data,
    input wire [1:0] rd_bank,
    output wire [15:0] rd_ptr,
    output wire [31:0] rd_word
);
    reg [15:0] ptr_ff [0:3]; // one pointer per bank, bank 0 unused
    reg [31:0] word_ff [0:3]; // last pre-fetched word per bank
    integer i;

    assign rd_ptr = ptr_ff[rd_bank];
    assign rd_word = word_ff[rd_bank];

    // banks are independent, so interleaved reads resume where they stopped
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 4; i = i + 1) begin
                ptr_ff[i] <= 16'h0000;
                word_ff[i] <= 32'h00000000;
            end
        end else begin
            if (load_en) begin
                ptr_ff[load_bank] <= load_addr;
            end
            if (fill_en) begin
                word_ff[fill_bank] <= fill_data;
            end
        end
    end
endmodule // prefetch_bank_store

// ===== rtl/irq_output_shaper.v
`timescale 1ns/100ps
`include "host_port_consts.vh"
// ****************************************
// interrupt pin: level or pulse, polarity, spacing
// ****************************************
module irq_output_shaper (
    input wire clk,
    input wire rst_n,
    input wire pending,
    input wire new_event,
    input wire global_en,
    input wire edge_mode,
    input wire active_high,
    input wire [15:0] pulse_width,
    input wire [7:0] min_space,
    output reg irq_ff
);
    reg [15:0] pulse_ff; // remaining pulse cycles
    reg [7:0] hold_ff; // remaining spacing ticks
    reg [8:0] tick_ff; // spacing prescaler
    reg armed_ff; // collected events awaiting a pulse
    reg level_act_ff; // last asserted state, for spacing start
    localparam integer TICK_LAST_INT = `IRQ_SPACE_TICK_CYC - 1; // last prescaler count
    localparam [8:0] TICK_LAST = TICK_LAST_INT[8:0];
    wire tick = (tick_ff == TICK_LAST);
    wire start = edge_mode & global_en & armed_ff & (pulse_ff == 16'h0000) & (hold_ff == 8'h00);
    wire lvl_go = ~edge_mode & global_en & pending & (hold_ff == 8'h00);
    wire act = edge_mode ? (pulse_ff != 16'h0000) : (lvl_go | (level_act_ff & pending));

    // shaping state; clearing status does not shorten a running pulse
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_ff <= 16'h0000;
            hold_ff <= 8'h00;
            tick_ff <= 9'h000;
            armed_ff <= 1'b0;
            level_act_ff <= 1'b0;
            irq_ff <= 1'b1; // active low by default, so idle high
        end else begin
            tick_ff <= tick ? 9'h000 : tick_ff + 9'h001;
            // an event in the start cycle keeps the pulse armed
            armed_ff <= new_event | (armed_ff & ~start);
            if (start) begin
                pulse_ff <= (pulse_width == 16'h0000) ? 16'h0001 : pulse_width;
            end else if (pulse_ff != 16'h0000) begin
                pulse_ff <= pulse_ff - 16'h0001;
            end
            if ((pulse_ff == 16'h0001) || (level_act_ff & ~act)) begin
                hold_ff <= min_space;
            end else if (tick && hold_ff != 8'h00) begin
                hold_ff <= hold_ff - 8'h01;
            end
            level_act_ff <= act & ~edge_mode;
            irq_ff <= active_high ? act : ~act;
        end
    end
endmodule // irq_output_shaper

// ===== rtl/host_port_prefetch_dma_irq.v
`timescale 1ns/100ps
`include "host_port_consts.vh"
// Functional notes
// - bus width from mode bit 8, except DMA configuration and pre-fetch address writes take all 32 bits
// - chip select or DMA acknowledge qualifies strobes
// - write read address plus bank first
// - bank reads return pre-fetched data, advance
// - independent pointer per bank, interleavable
// - bank reads pre-fetch only for buffer memory pointers; a pointer write always fills
// - writes and register accesses use bus address
// - DMA bursts of 1, 4, 8, 16 cycles at 32 bits, twice as many at 16
// - request drops on last strobe of burst
// - request and acknowledge polarity programmable
// - PIO between bursts leaves DMA state alone
// - no end pin; done sets status bit 3
// - burst size in bytes, width-independent
// - odd byte counts write only counted bytes
// - enable bit raises request at once
// - one DMA at a time, PIO concurrent
// - global enable, trigger type, polarity control interrupt
// - pulse width from low sixteen bits
// - top byte sets minimum interrupt spacing
// - events set own bit, write one clears
// - disabled sources set status, no interrupt
// - level interrupt holds until status cleared
module host_port_prefetch_dma_irq (
    input wire MCLK,
    input wire RST_N,
    input wire CS_N,
    input wire RD_N,
    input wire WR_N,
    input wire DMA_ACKNOWLEDGE_IN,
    input wire [17:0] ADDR,
    input wire [31:0] DATA_IN,
    output reg [31:0] DATA_OUT,
    output reg DATA_OE,
    output reg DMA_REQUEST_OUT,
    output wire IRQ_OUT,
    input wire [31:0] EVENT_IN,
    output reg [13:0] MEM_ADDR,
    output reg MEM_RD,
    output reg MEM_WR,
    output reg [3:0] MEM_BE,
    output reg [31:0] MEM_WDATA,
    input wire [31:0] MEM_RDATA
);
    // ****************************************
    // helper functions
    // ****************************************
    // merge a bus write into a register, half-word wide in 16-bit mode
    function [31:0] merge;
        input [31:0] old;
        input [31:0] din;
        input hi;
        input wide;
        begin
            if (wide) begin
                merge = din;
            end else if (hi) begin
                merge = {din[15:0], old[15:0]};
            end else begin
                merge = {old[31:16], din[15:0]};
            end
        end
    endfunction

    // pick the lane that the bus shows in 16-bit mode
    function [31:0] lane;
        input [31:0] word;
        input hi;
        input wide;
        begin
            lane = wide ? word : {16'h0000, (hi ? word[31:16] : word[15:0])};
        end
    endfunction

    // byte enables for a write of up to four remaining bytes
    function [3:0] enables;
        input [16:0] left;
        input hi;
        input wide;
        reg [3:0] part;
        begin
            part = 4'h0;
            if (wide) begin
                part = (left >= 17'h00004) ? 4'hF : (left == 17'h00003) ? 4'h7 :
                       (left == 17'h00002) ? 4'h3 : 4'h1;
            end else begin
                part = (left >= 17'h00002) ? 4'h3 : 4'h1;
                part = hi ? {part[1:0], 2'b00} : part;
            end
            enables = part;
        end
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    reg [3:0] s1_ff, s2_ff, s3_ff; // cs, rd, wr, ack pins
    reg [3:0] lvl_ff; // counted pin levels
    // a change counts once stages two and three agree
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            // idle levels; acknowledge defaults to active low, so it idles high
            s1_ff <= 4'hF;
            s2_ff <= 4'hF;
            s3_ff <= 4'hF;
            lvl_ff <= 4'hF;
        end else begin
            s1_ff <= {DMA_ACKNOWLEDGE_IN, WR_N, RD_N, CS_N};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= (s2_ff & s3_ff) | (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & lvl_ff);
        end
    end

    // ****************************************
    // registers
    // ****************************************
    reg [31:0] hw_mode_ff; // hardware_mode_control
    reg [31:0] irq_status_ff; // interrupt_status, write one to clear
    reg [31:0] irq_enable_ff; // interrupt_enable
    reg [31:0] edge_timing_ff; // edge_irq_timing
    reg [31:0] dma_cfg_ff; // dma_configuration
    reg [16:0] dma_count_ff; // transfer length in bytes
    reg [15:0] dma_start_ff; // dma_start_address
    reg [31:0] prefetch_reg_ff; // read_prefetch_address as written

    wire bus32 = hw_mode_ff[`HW_BUS32_BIT];
    wire ack_act = hw_mode_ff[`HW_ACK_HIGH_BIT] ? lvl_ff[3] : ~lvl_ff[3];
    wire sel = ~lvl_ff[0] | ack_act;
    wire rd_act = sel & ~lvl_ff[1];
    wire wr_act = sel & ~lvl_ff[2];
    reg rd_prev_ff, wr_prev_ff; // strobe history for start detection
    wire rd_go = rd_act & ~rd_prev_ff;
    wire wr_go = wr_act & ~wr_prev_ff;
    wire dma_cyc = ack_act; // acknowledge routes the strobe to the DMA
    wire [15:0] a = ADDR[15:0];
    wire [1:0] bank = ADDR[17:16];
    wire is_mem = (a >= `MEM_SPACE_LOW);
    wire [31:0] count_merged = merge({15'h0000, dma_count_ff}, DATA_IN, ADDR[1], bus32);

    // ****************************************
    // DMA engine state
    // ****************************************
    reg dma_on_ff; // transfer armed
    reg dma_dir_rd_ff; // 1: device to system
    reg [16:0] dma_left_ff; // bytes still to move
    reg [15:0] dma_cur_ff; // current memory byte address
    reg [5:0] dma_beat_ff; // strobes in this burst
    reg dma_wait_ff; // burst over, waiting for acknowledge release
    reg [31:0] dma_word_ff; // pre-fetched word for DMA reads

    wire [2:0] step = bus32 ? 3'd4 : 3'd2;
    wire [6:0] burst_bytes = (dma_cfg_ff[3:2] == 2'd0) ? 7'd4 : (dma_cfg_ff[3:2] == 2'd1) ? 7'd16 :
                             (dma_cfg_ff[3:2] == 2'd2) ? 7'd32 : 7'd64;
    wire [5:0] burst_beats = bus32 ? {1'b0, burst_bytes[6:2]} : burst_bytes[6:1];
    wire last_xfer = (dma_left_ff <= {14'h0000, step});
    wire dma_strobe = dma_on_ff & dma_cyc & (rd_go | wr_go);
    wire [15:0] dma_next_byte = dma_cur_ff + {13'h0000, step}; // address after this beat
    wire burst_end = (dma_beat_ff + 6'h01 == burst_beats);
    // request asserted while armed and not between bursts
    wire req_lvl = dma_on_ff & ~dma_wait_ff & ~(dma_strobe & (last_xfer | burst_end));

    // ****************************************
    // pre-fetch bank store
    // ****************************************
    reg [1:0] tag_ff, tag2_ff; // read return routing: 0 none 1 pio 2 bank 3 dma
    reg [1:0] fbank_ff, fbank2_ff; // bank of a pending fill
    reg hi_ff, hi2_ff; // lane of a pending pio read
    wire [15:0] bank_ptr;
    wire [31:0] bank_word;
    reg load_en;
    reg [15:0] load_addr;
    wire ptr_in_mem = (bank_ptr >= `MEM_SPACE_LOW);
    wire [15:0] bank_next = bank_ptr + {13'h0000, step}; // pointer after one bank read

    prefetch_bank_store u_banks (
        .clk(MCLK),
        .rst_n(RST_N),
        .load_en(load_en),
        .load_bank(load_en ? (wr_go ? DATA_IN[17:16] : bank) : 2'b00),
        .load_addr(load_addr),
        .fill_en(tag2_ff == 2'd2),
        .fill_bank(fbank2_ff),
        .fill_data(MEM_RDATA),
        .rd_bank(bank),
        .rd_ptr(bank_ptr),
        .rd_word(bank_word)
    );

    // pointer loads: on register write and on each bank read step
    always @* begin
        load_en = 1'b0;
        load_addr = 16'h0000;
        if (wr_go && !dma_cyc && a == `OFS_READ_PREFETCH_ADDRESS && DATA_IN[17:16] != 2'b00) begin
            load_en = 1'b1;
            load_addr = DATA_IN[15:0];
        end else if (rd_go && !dma_cyc && bank != 2'b00 && ptr_in_mem) begin
            load_en = 1'b1;
            load_addr = bank_next;
        end
    end

    // ****************************************
    // interrupt status and shaping
    // ****************************************
    wire dma_done = dma_strobe & last_xfer;
    wire [31:0] set_bits = EVENT_IN | ({31'h0, dma_done} << `IRQ_DMA_DONE_BIT);
    wire clr_hit = wr_go & ~dma_cyc & (a == `OFS_INTERRUPT_STATUS);
    wire [31:0] clr_bits = clr_hit ? merge(32'h0, DATA_IN, ADDR[1], bus32) : 32'h0;
    // set wins over a clear in the same cycle
    wire [31:0] nxt_status = (irq_status_ff & ~clr_bits) | set_bits;
    wire new_event = |(set_bits & ~irq_status_ff & irq_enable_ff);

    irq_output_shaper u_irq (
        .clk(MCLK),
        .rst_n(RST_N),
        .pending(|(irq_status_ff & irq_enable_ff)),
        .new_event(new_event),
        .global_en(hw_mode_ff[`HW_GLOBAL_EN_BIT]),
        .edge_mode(hw_mode_ff[`HW_TRIGGER_BIT]),
        .active_high(hw_mode_ff[`HW_POLARITY_BIT]),
        .pulse_width(edge_timing_ff[15:0]),
        .min_space(edge_timing_ff[31:24]),
        .irq_ff(IRQ_OUT)
    );

    // ****************************************
    // register read decode
    // ****************************************
    reg [31:0] reg_rd;
    always @* begin
        if (a == `OFS_HARDWARE_MODE_CONTROL) begin
            reg_rd = hw_mode_ff;
        end else if (a == `OFS_INTERRUPT_STATUS) begin
            reg_rd = irq_status_ff;
        end else if (a == `OFS_INTERRUPT_ENABLE) begin
            reg_rd = irq_enable_ff;
        end else if (a == `OFS_EDGE_IRQ_TIMING) begin
            reg_rd = edge_timing_ff;
        end else if (a == `OFS_DMA_CONFIGURATION) begin
            reg_rd = {dma_cfg_ff[31:2], dma_on_ff, dma_cfg_ff[0]};
        end else if (a == `OFS_DMA_TRANSFER_COUNT) begin
            reg_rd = {15'h0000, dma_left_ff};
        end else if (a == `OFS_DMA_START_ADDRESS) begin
            reg_rd = {16'h0000, dma_start_ff};
        end else if (a == `OFS_READ_PREFETCH_ADDRESS) begin
            reg_rd = prefetch_reg_ff;
        end else begin
            reg_rd = 32'h00000000; // unmapped reads as zero
        end
    end

    // ****************************************
    // main sequential process
    // ****************************************
    // one bus event per cycle, so one memory operation per cycle
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            hw_mode_ff <= `HW_MODE_RESET;
            irq_status_ff <= 32'h00000000;
            irq_enable_ff <= 32'h00000000;
            edge_timing_ff <= `EDGE_TIMING_RESET;
            dma_cfg_ff <= 32'h00000000;
            dma_count_ff <= 17'h00000;
            dma_start_ff <= 16'h0000;
            prefetch_reg_ff <= 32'h00000000;
            rd_prev_ff <= 1'b0;
            wr_prev_ff <= 1'b0;
            dma_on_ff <= 1'b0;
            dma_dir_rd_ff <= 1'b0;
            dma_left_ff <= 17'h00000;
            dma_cur_ff <= 16'h0000;
            dma_beat_ff <= 6'h00;
            dma_wait_ff <= 1'b0;
            dma_word_ff <= 32'h00000000;
            tag_ff <= 2'd0;
            tag2_ff <= 2'd0;
            fbank_ff <= 2'b00;
            fbank2_ff <= 2'b00;
            hi_ff <= 1'b0;
            hi2_ff <= 1'b0;
            DATA_OUT <= 32'h00000000;
            DATA_OE <= 1'b0;
            DMA_REQUEST_OUT <= 1'b1; // inactive for the default active-low request
            MEM_ADDR <= 14'h0000;
            MEM_RD <= 1'b0;
            MEM_WR <= 1'b0;
            MEM_BE <= 4'h0;
            MEM_WDATA <= 32'h00000000;
        end else begin
            rd_prev_ff <= rd_act;
            wr_prev_ff <= wr_act;
            irq_status_ff <= nxt_status;
            MEM_RD <= 1'b0;
            MEM_WR <= 1'b0;
            tag_ff <= 2'd0;
            tag2_ff <= tag_ff;
            fbank2_ff <= fbank_ff;
            hi2_ff <= hi_ff;
            DATA_OE <= rd_act; // drive the bus only while a read is held
            // returning memory data, one cycle after the read request
            if (tag2_ff == 2'd1) begin
                DATA_OUT <= lane(MEM_RDATA, hi2_ff, bus32);
            end else if (tag2_ff == 2'd3) begin
                dma_word_ff <= MEM_RDATA;
            end
            // request level follows the programmed polarity
            DMA_REQUEST_OUT <= hw_mode_ff[`HW_REQ_HIGH_BIT] ? req_lvl : ~req_lvl;
            if (dma_strobe) begin
                // DMA beat; PIO never reaches this branch
                dma_left_ff <= last_xfer ? 17'h00000 : dma_left_ff - {14'h0000, step};
                dma_cur_ff <= dma_cur_ff + {13'h0000, step};
                dma_beat_ff <= dma_beat_ff + 6'h01;
                if (last_xfer) begin
                    dma_on_ff <= 1'b0;
                end else if (dma_beat_ff + 6'h01 == burst_beats) begin
                    dma_wait_ff <= 1'b1;
                    dma_beat_ff <= 6'h00;
                end
                if (dma_dir_rd_ff) begin
                    DATA_OUT <= lane(dma_word_ff, dma_cur_ff[1], bus32);
                    MEM_RD <= 1'b1;
                    MEM_ADDR <= dma_next_byte[15:2];
                    tag_ff <= 2'd3;
                end else begin
                    MEM_WR <= 1'b1;
                    MEM_ADDR <= dma_cur_ff[15:2];
                    MEM_BE <= enables(dma_left_ff, dma_cur_ff[1], bus32);
                    MEM_WDATA <= bus32 ? DATA_IN : {DATA_IN[15:0], DATA_IN[15:0]};
                end
            end else if (dma_cyc) begin
                // acknowledge with no armed transfer is ignored
            end else if (wr_go && is_mem) begin
                MEM_WR <= 1'b1;
                MEM_ADDR <= a[15:2];
                MEM_BE <= bus32 ? 4'hF : (ADDR[1] ? 4'hC : 4'h3);
                MEM_WDATA <= bus32 ? DATA_IN : {DATA_IN[15:0], DATA_IN[15:0]};
            end else if (wr_go) begin
                if (a == `OFS_HARDWARE_MODE_CONTROL) begin
                    hw_mode_ff <= merge(hw_mode_ff, DATA_IN, ADDR[1], bus32);
                end else if (a == `OFS_INTERRUPT_ENABLE) begin
                    irq_enable_ff <= merge(irq_enable_ff, DATA_IN, ADDR[1], bus32);
                end else if (a == `OFS_EDGE_IRQ_TIMING) begin
                    edge_timing_ff <= merge(edge_timing_ff, DATA_IN, ADDR[1], bus32);
                end else if (a == `OFS_DMA_TRANSFER_COUNT) begin
                    dma_count_ff <= count_merged[16:0];
                end else if (a == `OFS_DMA_START_ADDRESS) begin
                    dma_start_ff <= bus32 ? {DATA_IN[15:2], 2'b00} : {DATA_IN[15:1], 1'b0};
                end else if (a == `OFS_READ_PREFETCH_ADDRESS) begin
                    prefetch_reg_ff <= DATA_IN;
                    if (DATA_IN[17:16] != 2'b00) begin
                        MEM_RD <= 1'b1;
                        MEM_ADDR <= DATA_IN[15:2];
                        tag_ff <= 2'd2;
                        fbank_ff <= DATA_IN[17:16];
                    end
                end else if (a == `OFS_DMA_CONFIGURATION) begin
                    dma_cfg_ff <= DATA_IN;
                    // a new transfer replaces any running one
                    if (DATA_IN[`DCFG_ENABLE_BIT] && dma_count_ff != 17'h00000) begin
                        dma_on_ff <= 1'b1;
                        dma_dir_rd_ff <= DATA_IN[`DCFG_DIR_BIT];
                        dma_left_ff <= dma_count_ff;
                        dma_cur_ff <= dma_start_ff;
                        dma_beat_ff <= 6'h00;
                        dma_wait_ff <= 1'b0;
                        MEM_RD <= DATA_IN[`DCFG_DIR_BIT];
                        MEM_ADDR <= dma_start_ff[15:2];
                        tag_ff <= DATA_IN[`DCFG_DIR_BIT] ? 2'd3 : 2'd0;
                    end else begin
                        dma_on_ff <= 1'b0;
                    end
                end
            end else if (rd_go && bank != 2'b00 && ptr_in_mem) begin
                // banked read: low address lines ignored, refill from the stepped pointer
                DATA_OUT <= lane(bank_word, bank_ptr[1], bus32);
                MEM_RD <= 1'b1;
                MEM_ADDR <= bank_next[15:2];
                tag_ff <= 2'd2;
                fbank_ff <= bank;
            end else if (rd_go && is_mem) begin
                MEM_RD <= 1'b1;
                MEM_ADDR <= a[15:2];
                tag_ff <= 2'd1;
                hi_ff <= ADDR[1];
            end else if (rd_go) begin
                DATA_OUT <= lane(reg_rd, ADDR[1], bus32);
            end
            // next burst may start once acknowledge is released
            if (dma_wait_ff && !dma_cyc && !dma_strobe) begin
                dma_wait_ff <= 1'b0;
            end
        end
    end
endmodule // host_port_prefetch_dma_irq

// ===== testbench/hp_checker.sv
`timescale 1ns/100ps
// ****
// strobe and memory pulse checks
// ****
module hp_checker(
    input wire MCLK,
    input wire RST_N,
    input wire RD_N,
    input wire WR_N,
    input wire DATA_OE,
    input wire MEM_RD,
    input wire MEM_WR
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    a_oe_needs_read: assert property ($rose(DATA_OE) |-> !$past(RD_N, 2))
        else $error("drive without read");
    a_oe_not_write: assert property ($rose(DATA_OE) |-> $past(WR_N, 2))
        else $error("drive during write");
    a_oe_holds: assert property ($rose(DATA_OE) |-> DATA_OE [*4])
        else $error("drive too short");
    a_oe_release: assert property ($rose(RD_N) |-> ##[1:8] !DATA_OE)
        else $error("drive not released");
    a_wr_needs_strobe: assert property (MEM_WR |-> !$past(WR_N, 2))
        else $error("write without strobe");
    a_wr_not_read: assert property (MEM_WR |-> $past(RD_N, 2))
        else $error("write during read");
    a_wr_single: assert property (MEM_WR |=> !MEM_WR)
        else $error("write repeated");
    a_rd_wr_apart: assert property (!(MEM_RD && MEM_WR))
        else $error("read and write together");
endmodule // hp_checker

// ===== testbench/buf_ram_model.sv
`timescale 1ns/100ps
// ****
// buffer ram: byte lanes, data the cycle after a read pulse
// ****
module buf_ram_model(
    input wire MCLK,
    input wire MEM_RD,
    input wire MEM_WR,
    input wire [13:0] MEM_ADDR,
    input wire [3:0] MEM_BE,
    input wire [31:0] MEM_WDATA,
    output reg [31:0] MEM_RDATA
);
    reg [31:0] mem [0:15];
    integer i;
    // stale data toggles so a late sample never matches
    always @(posedge MCLK) begin
        for (i = 0; i < 4; i = i + 1)
            if (MEM_WR && MEM_BE[i]) mem[MEM_ADDR[3:0]][8*i+:8] <= MEM_WDATA[8*i+:8];
        MEM_RDATA <= MEM_RD ? mem[MEM_ADDR[3:0]] : ~MEM_RDATA;
    end
endmodule // buf_ram_model

// ===== testbench/host_port_prefetch_dma_irq_tb_top.sv
`timescale 1ns/100ps
module host_port_prefetch_dma_irq_tb_top;
    reg mclk = 0, rst_n = 0, cs_n = 1, rd_n = 1, wr_n = 1, ack = 1; // ack active low
    reg [17:0] addr = 0;
    reg [31:0] din = 0, ev = 0;
    wire [31:0] dout, mrd, mwd;
    wire oe, req, irq, mr, mw;
    wire [13:0] ma;
    wire [3:0] be;
    integer fails = 0, n_compared = 0, k, j;
    always #5 mclk = ~mclk;
    host_port_prefetch_dma_irq dut_u(.MCLK(mclk), .RST_N(rst_n), .CS_N(cs_n), .RD_N(rd_n),
        .WR_N(wr_n), .DMA_ACKNOWLEDGE_IN(ack), .ADDR(addr), .DATA_IN(din), .DATA_OUT(dout),
        .DATA_OE(oe), .DMA_REQUEST_OUT(req), .IRQ_OUT(irq), .EVENT_IN(ev), .MEM_ADDR(ma),
        .MEM_RD(mr), .MEM_WR(mw), .MEM_BE(be), .MEM_WDATA(mwd), .MEM_RDATA(mrd));
    buf_ram_model ram_u(.MCLK(mclk), .MEM_RD(mr), .MEM_WR(mw), .MEM_ADDR(ma), .MEM_BE(be),
        .MEM_WDATA(mwd), .MEM_RDATA(mrd));
    task check(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task complete_run;
        begin
            $display("compared %0d failed %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // one strobe, qualified by select or acknowledge; reads compare the data
    task acc(input w, input dma, input [17:0] a, input [31:0] d);
        begin
            @(posedge mclk);
            addr <= a;
            din <= d;
            cs_n <= dma;
            ack <= !dma;
            if (w) wr_n <= 0; else rd_n <= 0;
            for (k = 0; !w && oe !== 1'b1 && k < 12; k = k + 1)
                @(posedge mclk);
            if (k == 12) begin
                fails = fails + 1;
                complete_run;
            end
            repeat (6) @(posedge mclk);
            if (!w) check(dout, d);
            cs_n <= 1;
            ack <= 1;
            rd_n <= 1;
            wr_n <= 1;
            repeat (6) @(posedge mclk);
        end
    endtask
    // event pulse, then settle
    task pulse(input [31:0] e);
        begin
            @(posedge mclk);
            ev <= e;
            @(posedge mclk);
            ev <= 0;
            repeat (5) @(posedge mclk);
        end
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1;
        acc(1, 0, 18'h00300, 32'h00000140);
        acc(0, 0, 18'h00300, 32'h00000140);
        for (j = 0; j < 3; j = j + 1)
            acc(1, 0, 18'h01000 + j[17:0] * 4, 32'hA5000000 + j);
        acc(0, 0, 18'h01004, 32'hA5000001);
        acc(1, 0, 18'h0033C, 32'h00011000);
        acc(1, 0, 18'h0033C, 32'h00021004);
        acc(0, 0, 18'h10000, 32'hA5000000);
        acc(0, 0, 18'h20000, 32'hA5000001);
        acc(0, 0, 18'h1FFF0, 32'hA5000001);
        acc(0, 0, 18'h20000, 32'hA5000002);
        acc(1, 0, 18'h00338, 32'h00002010);
        acc(1, 0, 18'h00334, 32'h00000004);
        acc(1, 0, 18'h00330, 32'h00000002);
        check(req, 1);
        acc(1, 1, 18'h00000, 32'h5A5AC3C3);
        check(req, 0);
        acc(0, 0, 18'h02010, 32'h5A5AC3C3);
        acc(0, 0, 18'h00310, 32'h00000008);
        acc(1, 0, 18'h00310, 32'h00000008);
        acc(1, 0, 18'h00314, 32'h00000008);
        acc(1, 0, 18'h00300, 32'h00000141);
        pulse(32'h00000008);
        check(irq, 0);
        acc(0, 0, 18'h00310, 32'h00000008);
        check(irq, 0);
        acc(1, 0, 18'h00310, 32'h00000008);
        check(irq, 1);
        pulse(32'h00000010);
        check(irq, 1);
        acc(0, 0, 18'h00310, 32'h00000010);
        complete_run;
    end
endmodule // host_port_prefetch_dma_irq_tb_top
bind host_port_prefetch_dma_irq hp_checker chk_u(.MCLK(MCLK), .RST_N(RST_N), .RD_N(RD_N),
    .WR_N(WR_N), .DATA_OE(DATA_OE), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR));
